// ---- rtl/acd_map.svh ----
// offsets, field positions, reset values and counts of the serial configuration decoder
// assumes the frame word is numbered 15 (first bit shifted in) down to 0
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH

// frame length in serial clock cycles
`define ACD_FRAME_BITS 5'd16
`define ACD_LAST_BIT_IDX 5'd15

// leading frame bits
`define ACD_BIT_WRITE 15
`define ACD_BIT_ZERO 14
`define ACD_BIT_REGSEL 13

// control payload within the frame word
`define ACD_CTRL_HI 11
`define ACD_CTRL_LO 0

// range payload within the frame word
`define ACD_RANGE_HI 12
`define ACD_RANGE_LO 7

// fields of the conversion_setup register
`define ACD_C_CHAN 10
`define ACD_C_MODE_HI 9
`define ACD_C_MODE_LO 8
`define ACD_C_PM_HI 7
`define ACD_C_PM_LO 6
`define ACD_C_CODING 5
`define ACD_C_REF 4
`define ACD_C_SEQ_A 3
`define ACD_C_SEQ_B 2

// fields of the 6-bit range register
`define ACD_R_CH0_HI 5
`define ACD_R_CH0_LO 4
`define ACD_R_CH1_HI 1
`define ACD_R_CH1_LO 0

// reset values
`define ACD_SETUP_RST 12'h000
`define ACD_RANGE_RST 6'h00
// synchroniser resets to the idle pin levels {din, cs_n, sclk}, so no false edge follows reset
`define ACD_SYNC_RST 3'h3

// power-down point: index of the serial clock rising edge inside a frame, counted from 1
`define ACD_PD_RISE_EDGE 5'd15

// result coding: offset code to two's complement flips the sign bit
`define ACD_SIGN_FLIP 13'h1000

`endif

// ---- rtl/acd_pkg.sv ----
// types shared by the serial configuration decoder
// assumes nothing of its surroundings
package acd_pkg;

    typedef enum logic [1:0] {
        ACD_FS_IDLE  = 2'b00,
        ACD_FS_SHIFT = 2'b01,
        ACD_FS_HOLD  = 2'b10
    } acd_frame_t;

    typedef enum logic [1:0] {
        ACD_PWR_NORMAL   = 2'b00,
        ACD_PWR_STANDBY  = 2'b01,
        ACD_PWR_SHUTDOWN = 2'b10
    } acd_power_t;

    typedef enum logic [1:0] {
        ACD_PM_NORMAL   = 2'b00,
        ACD_PM_AUTOSTBY = 2'b01,
        ACD_PM_AUTOSHDN = 2'b10,
        ACD_PM_FULLSHDN = 2'b11
    } acd_pm_t;

    typedef enum logic [1:0] {
        ACD_IN_SINGLE = 2'b00,
        ACD_IN_PSEUDO = 2'b01,
        ACD_IN_DIFF   = 2'b10,
        ACD_IN_BAD    = 2'b11
    } acd_inmode_t;

endpackage

// ---- rtl/acd_serial_cfg.sv ----
// serial configuration decoder of a two-channel converter: frame shifter,
// write decode, conversion_setup and range registers, sequencer and power state
// assumes sclk, cs_n and din come from a host in another clock domain and that
// sclk runs well below a quarter of i_clk
//
// Contract
// - a frame is sixteen serial clocks; only those sixteen bits are decoded
// - the first three shifted bits choose which register the frame addresses
// - leading bits are write flag, zero bit, register choice, MSB first
// - write flag 0 means the frame is ignored and registers stay unchanged
// - write 1, choice 0 loads the last twelve bits into conversion_setup
// - write 1, choice 1 loads the next six bits into the range register
// - both registers are write-only; nothing is read back serially
// - new control settings apply to the next conversion after the write
// - conversion_setup clears to zero at power-up
// - channel bit picks the next channel, or the last channel in sequence mode
// - mode bits with the channel bit set single-ended, differential or pseudo
// - the two power bits select the power mode
// - coding bit 0 gives two's complement, 1 gives straight binary
// - in sequence mode every result uses the latest written coding
// - reference bit 0 uses external, 1 uses internal reference
// - in sequence mode every channel uses the latest written reference choice
// - the two sequencer bits set the sequencer mode
// - pseudo differential: pseudo ground gives -4096, full amplitude +4095
// - power codes: 11 shutdown, 10 autoshutdown, 01 autostandby, 00 normal
// - sequencer 1 then 0 runs channel 0 up to the final channel
// - input mode 11 illegal, 10 differential, 01 pseudo, 00 single-ended
// - range register has two bits per channel, reset to widest bipolar
`timescale 1ns/10ps
`include "acd_map.svh"
module acd_serial_cfg
    import acd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // serial pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    // raw result from the conversion core, offset code
    input wire logic [12:0] i_raw_result,
    input wire logic i_raw_valid,
    // register contents toward the analog side
    output logic [11:0] o_setup,
    output logic [5:0] o_range,
    output logic o_write_ctrl,
    output logic o_write_range,
    // settings of the conversion in progress
    output logic o_conv_start,
    output logic o_conv_ch,
    output logic [1:0] o_conv_mode,
    output logic [1:0] o_conv_range,
    output logic o_conv_coding,
    output logic o_conv_ref,
    output logic o_cfg_illegal,
    output logic o_seq_active,
    // power
    output logic [1:0] o_power_state,
    output logic o_int_ref_en,
    // coded result
    output logic [12:0] o_result,
    output logic o_result_valid
);

    // frame word decode into {control write, range write}
    function automatic logic [1:0] acd_decode(input logic [15:0] word);
        logic wr;
        logic sel;
        wr = word[`ACD_BIT_WRITE];
        sel = word[`ACD_BIT_REGSEL];
        // the zero bit is not checked; the host owns it
        acd_decode = {wr & ~sel, wr & sel};
    endfunction

    // range bits of one channel
    function automatic logic [1:0] acd_range_of(input logic [5:0] rng, input logic ch);
        acd_range_of = ch ? rng[`ACD_R_CH1_HI:`ACD_R_CH1_LO]
                          : rng[`ACD_R_CH0_HI:`ACD_R_CH0_LO];
    endfunction

    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic din_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    acd_sync #(
        .W(3),
        .RST_VAL(`ACD_SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_din, i_cs_n, i_sclk}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    assign din_s = pin_level[2];
    assign sclk_rise = pin_rise[0];
    assign sclk_fall = pin_fall[0];
    assign cs_fall = pin_fall[1];
    assign cs_rise = pin_rise[1];
    acd_frame_t state_q;
    acd_frame_t state_d;
    logic [4:0] bit_cnt_q;
    logic [4:0] rise_cnt_q;
    logic [15:0] shift_q;
    logic [15:0] word_d;
    logic take;
    logic wr_ctrl;
    logic wr_range;
    logic pd_hit;
    logic [11:0] setup_q;
    logic [5:0] range_q;
    logic seq_ptr_q;
    logic seq_on;
    logic conv_ch_d;
    acd_pm_t pm_cur;
    acd_pm_t pm_new;
    acd_power_t power_q;

    // frame state: start on chip select falling, stop after the sixteenth bit
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACD_FS_IDLE: begin
                if (cs_fall) begin
                    state_d = ACD_FS_SHIFT;
                end
            end
            ACD_FS_SHIFT: begin
                if (cs_rise) begin
                    state_d = ACD_FS_IDLE;
                end else if (take) begin
                    state_d = ACD_FS_HOLD;
                end
            end
            ACD_FS_HOLD: begin
                if (cs_rise) begin
                    state_d = ACD_FS_IDLE;
                end
            end
            default: begin
                state_d = ACD_FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= ACD_FS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bits are taken on the serial clock falling edge, MSB first
    assign take = (state_q == ACD_FS_SHIFT) && !cs_rise && sclk_fall
                  && (bit_cnt_q == `ACD_LAST_BIT_IDX);
    assign word_d = {shift_q[14:0], din_s};
    assign {wr_ctrl, wr_range} = {2{take}} & acd_decode(word_d);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 16'h0000;
        end else if (state_q == ACD_FS_SHIFT && sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q <= word_d;
        end
    end

    // rising edges inside the frame, for the auto power-down point
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rise_cnt_q <= 5'h00;
        end else if (cs_fall) begin
            rise_cnt_q <= 5'h00;
        end else if (state_q != ACD_FS_IDLE && sclk_rise && rise_cnt_q != 5'h1f) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end

    assign pd_hit = (state_q != ACD_FS_IDLE) && sclk_rise
                    && (rise_cnt_q == `ACD_PD_RISE_EDGE - 5'h01);

    // registers; there is no serial read path for either of them
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            setup_q <= `ACD_SETUP_RST;
        end else if (wr_ctrl) begin
            setup_q <= word_d[`ACD_CTRL_HI:`ACD_CTRL_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            range_q <= `ACD_RANGE_RST;
        end else if (wr_range) begin
            range_q <= word_d[`ACD_RANGE_HI:`ACD_RANGE_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_write_ctrl <= 1'b0;
            o_write_range <= 1'b0;
        end else begin
            o_write_ctrl <= wr_ctrl;
            o_write_range <= wr_range;
        end
    end

    assign o_setup = setup_q;
    assign o_range = range_q;

    // sequencer: a 1/0 pair of sequencer bits walks from channel 0 to the channel bit
    assign seq_on = setup_q[`ACD_C_SEQ_A] & ~setup_q[`ACD_C_SEQ_B];
    assign conv_ch_d = seq_on ? seq_ptr_q : setup_q[`ACD_C_CHAN];

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            seq_ptr_q <= 1'b0;
        end else if (wr_ctrl) begin
            seq_ptr_q <= 1'b0;
        end else if (cs_fall && seq_on) begin
            seq_ptr_q <= (seq_ptr_q == setup_q[`ACD_C_CHAN]) ? 1'b0 : ~seq_ptr_q;
        end
    end

    // settings are frozen at chip select falling, so a write affects the next conversion
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_conv_ch <= 1'b0;
            o_conv_mode <= ACD_IN_SINGLE;
            o_conv_range <= 2'h0;
            o_conv_coding <= 1'b0;
            o_conv_ref <= 1'b0;
            o_cfg_illegal <= 1'b0;
            o_seq_active <= 1'b0;
        end else if (cs_fall) begin
            o_conv_mode <= setup_q[`ACD_C_MODE_HI:`ACD_C_MODE_LO];
            o_cfg_illegal <= (setup_q[`ACD_C_MODE_HI:`ACD_C_MODE_LO] == ACD_IN_BAD);
            o_conv_coding <= setup_q[`ACD_C_CODING];
            o_conv_ref <= setup_q[`ACD_C_REF];
            o_seq_active <= seq_on;
            // paired modes always measure vin0 against vin1 and take channel 0's range
            if (setup_q[`ACD_C_MODE_HI:`ACD_C_MODE_LO] == ACD_IN_SINGLE) begin
                o_conv_ch <= conv_ch_d;
                o_conv_range <= acd_range_of(range_q, conv_ch_d);
            end else begin
                o_conv_ch <= 1'b0;
                o_conv_range <= acd_range_of(range_q, 1'b0);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= cs_fall;
        end
    end

    // power state: full shutdown follows the write, the auto modes the fifteenth edge
    assign pm_cur = acd_pm_t'(setup_q[`ACD_C_PM_HI:`ACD_C_PM_LO]);
    assign pm_new = acd_pm_t'(word_d[`ACD_C_PM_HI:`ACD_C_PM_LO]);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            power_q <= ACD_PWR_NORMAL;
        end else if (wr_ctrl) begin
            case (pm_new)
                ACD_PM_FULLSHDN: begin
                    power_q <= ACD_PWR_SHUTDOWN;
                end
                ACD_PM_NORMAL: begin
                    power_q <= ACD_PWR_NORMAL;
                end
                default: begin
                    power_q <= power_q;
                end
            endcase
        end else if (cs_fall && pm_cur != ACD_PM_FULLSHDN) begin
            power_q <= ACD_PWR_NORMAL;
        end else if (pd_hit) begin
            case (pm_cur)
                ACD_PM_AUTOSHDN: begin
                    power_q <= ACD_PWR_SHUTDOWN;
                end
                ACD_PM_AUTOSTBY: begin
                    power_q <= ACD_PWR_STANDBY;
                end
                default: begin
                    power_q <= power_q;
                end
            endcase
        end
    end
    assign o_power_state = power_q;

    // standby keeps the internal reference alive, shutdown does not
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_int_ref_en <= 1'b0;
        end else begin
            o_int_ref_en <= setup_q[`ACD_C_REF] && (power_q != ACD_PWR_SHUTDOWN);
        end
    end

    // offset code to two's complement by flipping the sign bit, so pseudo ground
    // maps to the most negative code
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_result <= 13'h0000;
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= i_raw_valid;
            if (i_raw_valid) begin
                o_result <= o_conv_coding ? i_raw_result
                                          : (i_raw_result ^ `ACD_SIGN_FLIP);
            end
        end
    end

endmodule

// ---- rtl/acd_sync.sv ----
// two-flop synchroniser with a third stage for edge detection
// assumes the inputs are asynchronous to i_clk
`timescale 1ns/10ps
module acd_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // asynchronous inputs
    input wire logic [W-1:0] i_async,
    // synchronised level and edges
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    // meta_q feeds sync_q only
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            last_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise = sync_q & ~last_q;
    assign o_fall = ~sync_q & last_q;

endmodule

// ---- tb/acd_host_model.sv ----
// host side of the serial link: frames on sclk, cs_n and din
// assumes the decoder samples din on sclk falling edges; sclk idles high between frames
`timescale 1ns/10ps
module acd_host_model (
    // serial pins toward the device
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end

    // sends the top n bits of w, msb first; n below 16 aborts the frame
    task automatic send(input logic [15:0] w, input int n);
        o_cs_n = 1'b0;
        for (int b = 15; b > 15 - n; b--) begin
            o_din = w[b];
            #62.5 o_sclk = 1'b0;
            #62.5 o_sclk = 1'b1;
        end
        #62.5 o_cs_n = 1'b1;
        // released line shows the inverse so a stale bit is never taken for data
        o_din = ~o_din;
        #100;
    endtask
endmodule

// ---- tb/acd_serial_cfg_assertions.sv ----
// timing checks on the ports of the serial configuration decoder
// assumes it is bound to acd_serial_cfg and sees only that module's ports
`timescale 1ns/10ps
module acd_cfg_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // watched inputs
    input wire logic i_cs_n,
    input wire logic [12:0] i_raw_result,
    input wire logic i_raw_valid,
    // watched outputs
    input wire logic [11:0] o_setup,
    input wire logic [5:0] o_range,
    input wire logic o_write_ctrl,
    input wire logic o_write_range,
    input wire logic o_conv_start,
    input wire logic o_conv_coding,
    input wire logic o_conv_ref,
    input wire logic o_cfg_illegal,
    input wire logic o_seq_active,
    input wire logic [1:0] o_power_state,
    input wire logic o_int_ref_en,
    input wire logic [12:0] o_result,
    input wire logic o_result_valid
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    AST_SETUP_HOLD: assert property (!o_write_ctrl |-> o_setup == $past(o_setup))
        else $error("setup changed without a control write");
    AST_RANGE_HOLD: assert property (!o_write_range |-> o_range == $past(o_range))
        else $error("range changed without a range write");
    AST_ONE_TARGET: assert property (!(o_write_ctrl && o_write_range))
        else $error("both registers written by one frame");
    AST_PULSE_SHORT: assert property (o_write_ctrl |=> !o_write_ctrl ##1 !o_write_ctrl)
        else $error("control write pulse repeated");
    AST_IN_FRAME: assert property (o_write_ctrl || o_write_range |-> $past(i_cs_n, 4) == 1'b0)
        else $error("write taken outside a selected frame");
    AST_CODED_RESULT: assert property (i_raw_valid |=> o_result_valid && o_result ==
        ($past(o_conv_coding) ? $past(i_raw_result) : ($past(i_raw_result) ^ 13'h1000)))
        else $error("result coding wrong");
    AST_LATCHED_CFG: assert property (o_conv_start |-> o_conv_coding == o_setup[5]
        && o_conv_ref == o_setup[4] && o_seq_active == (o_setup[3:2] == 2'b10))
        else $error("conversion settings not taken from setup");
    AST_ILLEGAL_MODE: assert property (o_conv_start |-> o_cfg_illegal == (o_setup[9:8] == 2'b11))
        else $error("illegal input mode flag wrong");
    AST_FULL_SHDN: assert property (o_write_ctrl && o_setup[7:6] == 2'b11 |-> o_power_state == 2'b10)
        else $error("full shutdown not entered on write");
    AST_INT_REF: assert property ($stable(o_power_state) && $stable(o_setup) |->
        o_int_ref_en == (o_setup[4] && o_power_state != 2'b10))
        else $error("internal reference enable wrong");
endmodule

bind acd_serial_cfg acd_cfg_checker i_acd_cfg_checker (.*);

// ---- tb/test_adc_serial_config_decoder.sv ----
// self-checking bench of the serial configuration decoder
// assumes the host model on the serial pins and a 100 MHz system clock
`timescale 1ns/10ps
module test_adc_serial_config_decoder;
    logic i_clk, i_sys_rst, sclk, cs_n, din, i_raw_valid;
    logic [12:0] i_raw_result, o_result;
    logic [11:0] o_setup;
    logic [5:0] o_range;
    logic [1:0] o_conv_mode, o_power_state, o_conv_range;
    logic o_write_ctrl, o_write_range, o_conv_start, o_conv_ch, o_conv_coding, o_conv_ref;
    logic o_cfg_illegal, o_seq_active, o_int_ref_en, o_result_valid;
    int errors, samples_checked, cycles;

    acd_host_model i_acd_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    acd_serial_cfg i_acd_serial_cfg (.i_clk, .i_sys_rst, .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_raw_result, .i_raw_valid, .o_setup, .o_range, .o_write_ctrl,
        .o_write_range, .o_conv_start, .o_conv_ch, .o_conv_mode, .o_conv_range,
        .o_conv_coding, .o_conv_ref, .o_cfg_illegal, .o_seq_active, .o_power_state,
        .o_int_ref_en, .o_result, .o_result_valid);

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the write pulse lands a few clocks after the last sclk fall, long before return
    task automatic frame(input logic [15:0] w, input int n = 16);
        i_acd_host_model.send(w, n);
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    task automatic wr_ctl(input logic [11:0] c);
        frame({4'h8, c});
    endtask

    task automatic raw(input logic [12:0] v, input logic [12:0] exp);
        @(posedge i_clk);
        #1;
        i_raw_result = v;
        i_raw_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_raw_valid = 1'b0;
        chk("result", 16'(exp), 16'(o_result));
        chk("result_valid", 16'h1, 16'(o_result_valid));
    endtask

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // a hang costs a mismatch; the whole sequence needs well under 8000 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        i_sys_rst = 1'b1;
        i_raw_valid = 1'b0;
        i_raw_result = 13'h0000;
        repeat (16) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        chk("setup", 16'h0, 16'(o_setup));
        chk("range", 16'h0, 16'(o_range));
        frame(16'hb080);
        chk("range", 16'h21, 16'(o_range));
        chk("setup", 16'h0, 16'(o_setup));
        wr_ctl(12'h6ac);
        chk("setup", 16'h6ac, 16'(o_setup));
        chk("range", 16'h21, 16'(o_range));
        frame(16'h1fff);
        chk("setup", 16'h6ac, 16'(o_setup));
        chk("range", 16'h21, 16'(o_range));
        chk("conv_mode", 16'h2, 16'(o_conv_mode));
        chk("coding", 16'h1, 16'(o_conv_coding));
        chk("conv_range", 16'h2, 16'(o_conv_range));
        chk("power", 16'h2, 16'(o_power_state));
        raw(13'h1abc, 13'h1abc);
        frame(16'h8000, 8);
        chk("setup", 16'h6ac, 16'(o_setup));
        for (int k = 0; k < 4; k++) begin
            wr_ctl(12'(k * 12'h140));
            frame(16'h0000);
            chk("conv_mode", 16'(k), 16'(o_conv_mode));
            chk("illegal", 16'(k == 3), 16'(o_cfg_illegal));
            chk("power", (k == 0) ? 16'h0 : (k == 1) ? 16'h1 : 16'h2, 16'(o_power_state));
        end
        wr_ctl(12'h418);
        chk("int_ref", 16'h1, 16'(o_int_ref_en));
        for (int k = 0; k < 3; k++) begin
            frame(16'h0000);
            chk("seq_ch", 16'(k % 2), 16'(o_conv_ch));
            chk("seq_range", (k % 2) ? 16'h1 : 16'h2, 16'(o_conv_range));
            chk("ref", 16'h1, 16'(o_conv_ref));
            chk("seq", 16'h1, 16'(o_seq_active));
        end
        raw(13'h0000, 13'h1000);
        raw(13'h1fff, 13'h0fff);
        wr_ctl(12'h400);
        frame(16'h0000);
        chk("conv_ch", 16'h1, 16'(o_conv_ch));
        chk("conv_range", 16'h1, 16'(o_conv_range));
        chk("seq", 16'h0, 16'(o_seq_active));
        end_of_test();
    end
endmodule
